// ### hw/sld_driver.sv
// Serial LED latch driver: shift register, latch, gate, fault, watchdog
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Bits on the serial data input shift in, one per serial clock cycle.
// R2: A bit shifted in leaves the serial output eight serial clocks later.
// R3: The load strobe copies all eight shift bits into the output latch.
// R4: The gate input switches all eight outputs together, fast enough for PWM.
// R5: Each output is watched for an open LED without any request.
// R6: The load strobe rising edge puts the fault status in the shift register.
// R7: Captured fault bits leave on the serial output during the next transfer.
// R8: After more than 1 s without interface activity the latch is cleared.
// R9: A watchdog timeout leaves the shift register as it was.
// R10: After a watchdog clear only a later load brings outputs back on.
// R11: The gate is active low; high forces every output off.
// R12: Shift on rising serial clock; latch one means on; edges feed the dog.
module sld_driver
  import sld_pkg::*;
#(
  parameter int unsigned WDOG_CYC = sld_pkg::SLD_WDOG_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire sld_pkg::sld_link_s link_i,
  input wire logic out_gate_n_i,
  input wire logic [7:0] led_open_i,
  output logic ser_dout_o,
  output sld_pkg::sld_led_s led_o,
  output logic wdog_fired_o
);
  import sld_pkg::*;

  localparam int unsigned CW = $clog2(WDOG_CYC + 1);

  // Refuse a timeout too short for the end-of-count compare
  if (WDOG_CYC < 2) begin : g_bad_wdog
    $error("sld_driver: WDOG_CYC must be at least 2");
  end

  // Latency from a pin edge: two sync flops, one cycle to act, and one
  // more for the registered outputs. Each serial clock level must last more
  // than one system clock or its edge can be lost; the nominal link rate
  // leaves ample margin. Raw pin levels are never read directly, since
  // they can change at any time against the system clock.
  logic [2:0] link_s;
  logic gate_n_s;
  logic [7:0] open_s;
  logic ser_clk_prev_q;
  logic strobe_prev_q;
  logic [7:0] shift_q;
  logic [7:0] latch_q;
  logic [CW-1:0] wdog_q;
  logic clk_rise;
  logic strobe_rise;
  logic activity;
  logic wdog_expire;

  // Pins from outside cross in through two flops each
  // Gate and open status are pins too, so they share one bundle
  sld_sync #(.WIDTH(3)) u_link_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({link_i.ser_clk, link_i.ser_din, link_i.latch_load_strobe}),
    .sync_o(link_s)
  );
  sld_sync #(.WIDTH(9)) u_stat_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({out_gate_n_i, led_open_i}),
    .sync_o({gate_n_s, open_s})
  );

  // Edge memory on synchronised levels only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ser_clk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      ser_clk_prev_q <= link_s[2];
      strobe_prev_q <= link_s[0];
    end
  end

  assign clk_rise = link_s[2] & ~ser_clk_prev_q; // [R12]
  assign strobe_rise = link_s[0] & ~strobe_prev_q;
  assign activity = clk_rise | (link_s[0] ^ strobe_prev_q); // [R12]
  assign wdog_expire = (wdog_q == CW'(WDOG_CYC - 1));

  // Shift register; fault capture on the strobe wins over a shift, so a
  // serial bit clocked on the very edge of a load is lost
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      shift_q <= SLD_SHIFT_RST;
    end else if (strobe_rise) begin
      shift_q <= open_s; // [R5] [R6] [R7]
    end else if (clk_rise) begin
      shift_q <= {shift_q[6:0], link_s[1]}; // [R1] [R2]
    end
    // No watchdog term here, so a timeout keeps the contents [R9]
  end

  // Output latch: a new load beats a timeout in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      latch_q <= SLD_LATCH_RST;
    end else if (strobe_rise) begin
      latch_q <= shift_q; // [R3] [R10]
    end else if (wdog_expire) begin
      latch_q <= SLD_LATCH_RST; // [R8]
    end
  end

  // Inactivity counter, restarted by a serial clock rise or either strobe edge; it parks at its end
  // value, so an expired timer keeps the latch clear until the link wakes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wdog_q <= '0;
    end else if (activity) begin
      wdog_q <= '0; // [R12]
    end else if (!wdog_expire) begin
      wdog_q <= wdog_q + CW'(1);
    end
  end

  // Timeout flag; a timeout on the same edge as fresh activity still
  // counts; the latch was cleared on that edge unless a strobe rise loaded it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wdog_fired_o <= 1'b0;
    end else if (wdog_expire) begin
      wdog_fired_o <= 1'b1; // [R8]
    end else if (activity) begin
      wdog_fired_o <= 1'b0;
    end
  end

  // Outputs: serial out is the MSB, so a bit needs eight shifts to emerge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ser_dout_o <= 1'b0;
      led_o <= '0;
    end else begin
      ser_dout_o <= shift_q[7]; // [R2]
      // Gate is a plain AND, so PWM edges pass with a fixed three-cycle lag
      led_o.led_on <= gate_n_s ? 8'h00 : latch_q; // [R4] [R11]
      led_o.open_fault <= open_s; // [R5]
    end
  end

  // Shift path, latch, gate, fault capture and watchdog checks
  shift_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_rise && !strobe_rise |=>
      shift_q == {$past(shift_q[6:0]), $past(link_s[1])})
    else $error("shift step wrong"); // [R1]
  dout_msb_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    1 |=> ser_dout_o == $past(shift_q[7]))
    else $error("serial output not MSB"); // [R2]
  latch_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    strobe_rise |=> latch_q == $past(shift_q))
    else $error("latch not loaded"); // [R3]
  gate_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    gate_n_s |=> led_o.led_on == 8'h00)
    else $error("gate did not blank"); // [R11]
  gate_on_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !gate_n_s |=> led_o.led_on == $past(latch_q))
    else $error("outputs ignore latch"); // [R4]
  fault_cap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    strobe_rise |=> shift_q == $past(open_s))
    else $error("fault not captured"); // [R6]
  wdog_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wdog_expire && !activity && !strobe_rise |=> latch_q == 8'h00)
    else $error("watchdog did not clear"); // [R8]
  wdog_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wdog_expire && !activity |=> $stable(shift_q))
    else $error("timeout touched shift"); // [R9]
  wdog_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    latch_q == 8'h00 && !strobe_rise |=> latch_q == 8'h00)
    else $error("latch revived unloaded"); // [R10]
  activity_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    activity |=> wdog_q == '0)
    else $error("activity missed"); // [R12]

  // Shift idle, watchdog, fault path and load-to-output checks
  shift_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !clk_rise && !strobe_rise |=> $stable(shift_q))
    else $error("shift moved without clock"); // [R1]
  load_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    strobe_rise && !gate_n_s ##1 !gate_n_s |=>
      led_o.led_on == $past(shift_q, 2))
    else $error("load did not reach outputs"); // [R3]
  fault_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    1 |=> led_o.open_fault == $past(open_s))
    else $error("open status not shown"); // [R5]
  fault_dout_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    strobe_rise |-> ##2 ser_dout_o == $past(open_s[7], 2))
    else $error("fault bit not on serial out"); // [R7]
  fired_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wdog_expire |=> wdog_fired_o)
    else $error("timeout flag not set"); // [R8]
  fired_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    activity && !wdog_expire |=> !wdog_fired_o)
    else $error("timeout flag not cleared"); // [R8]
  wdog_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !strobe_rise && !wdog_expire |=> $stable(latch_q))
    else $error("latch changed early"); // [R8]
  wdog_park_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wdog_expire && !activity |=> wdog_expire)
    else $error("timer left end value"); // [R8]
  wdog_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !activity && !wdog_expire |=> wdog_q == $past(wdog_q) + CW'(1))
    else $error("timer did not count"); // [R8]

  load_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    strobe_rise && shift_q != 8'h00);
  fire_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wdog_expire && latch_q != 8'h00);
  pwm_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(gate_n_s) && latch_q != 8'h00);
  shift_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_rise && shift_q[7]);
  blank_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(gate_n_s) && latch_q != 8'h00);
endmodule : sld_driver
`default_nettype wire

// ### hw/sld_pkg.sv
// Package for the serial LED latch driver: constants and carrier structs
package sld_pkg;
  localparam int unsigned SLD_WIDTH = 8;
  // Watchdog timeout in milliseconds, and the system clock rate
  localparam int unsigned SLD_WDOG_MS = 1000;
  localparam int unsigned SLD_CLK_KHZ = 250_000;
  // More than 1 s of silence: the count of 4 ns cycles, an exact product
  localparam int unsigned SLD_WDOG_CYC = SLD_WDOG_MS * SLD_CLK_KHZ;
  localparam logic [7:0] SLD_LATCH_RST = 8'h00;
  localparam logic [7:0] SLD_SHIFT_RST = 8'h00;

  // Serial link pins as seen by the device
  typedef struct packed {
    logic ser_clk;
    logic ser_din;
    logic latch_load_strobe;
  } sld_link_s;

  // Per-output sink status
  typedef struct packed {
    logic [7:0] led_on;
    logic [7:0] open_fault;
  } sld_led_s;
endpackage : sld_pkg

// ### hw/sld_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sld_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // Refuse an empty bundle at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("sld_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : sld_sync
`default_nettype wire

// ### testbench/sld_host.sv
// Host model driving the serial link pins of the LED driver
`timescale 1ns/1ps
`default_nettype none
module sld_host (
  input wire logic ref_clk_i,
  input wire logic ser_dout_i,
  output sld_pkg::sld_link_s link_o
);
  import sld_pkg::*;
  // Link clock half period: one bit every 125 ns
  localparam realtime HALF = 62.5;
  // Link idles low; clock stands still between frames
  initial link_o = '0;
  // Shift one byte MSB first on the host's own timebase; the start offset
  // keeps every pin edge of the bit loop clear of a system clock edge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    #0.25;
    for (int i = 7; i >= 0; i--) begin
      link_o.ser_din <= d[i];
      #(HALF);
      q[i] = ser_dout_i; // Read before the rise
      link_o.ser_clk <= 1'b1;
      #(HALF);
      link_o.ser_clk <= 1'b0;
    end
    @(posedge ref_clk_i);
    link_o.ser_din <= ~d[0]; // No stale bit left on the line
  endtask : xfer
  // Load strobe pulse, held well beyond the sync delay
  task automatic load();
    link_o.latch_load_strobe <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    link_o.latch_load_strobe <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask : load
endmodule : sld_host
`default_nettype wire

// ### testbench/tb_top.sv
// Testbench for the serial LED latch driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sld_pkg::*;
  localparam int unsigned WDOG = 200;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gate_n = 1'b0;
  logic [7:0] open_in = 8'h00;
  logic [7:0] rd;
  logic ser_dout;
  logic fired;
  sld_link_s link;
  sld_led_s led;
  int n_errors = 0;
  int total_checks = 0;
  // Clock at 250 MHz
  always #2 ref_clk_i = ~ref_clk_i;
  sld_driver #(.WDOG_CYC(WDOG)) sld_driver_i (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .link_i(link), .out_gate_n_i(gate_n),
    .led_open_i(open_in), .ser_dout_o(ser_dout), .led_o(led),
    .wdog_fired_o(fired));
  sld_host sld_host_i (.ref_clk_i(ref_clk_i), .ser_dout_i(ser_dout),
    .link_o(link));
  // Byte compare, four-state exact
  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask : cmp
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_clk
  // Chain delay, load into latch and open status outputs
  task automatic t_chain();
    open_in <= 8'h3C;
    sld_host_i.xfer(8'hA5, rd);
    sld_host_i.xfer(8'h5A, rd);
    cmp("chain", 8'hA5, rd);
    sld_host_i.load();
    cmp("latch", 8'h5A, led.led_on);
    cmp("open", 8'h3C, led.open_fault);
  endtask : t_chain
  // Gate blanks all outputs together, then restores them
  task automatic t_gate();
    gate_n <= 1'b1;
    wait_clk(6);
    cmp("gate off", 8'h00, led.led_on);
    gate_n <= 1'b0;
    wait_clk(6);
    cmp("gate on", 8'h5A, led.led_on);
    sld_host_i.xfer(8'hC3, rd);
    cmp("faults", 8'h3C, rd);
  endtask : t_gate
  // Silence clears the latch only; a later load recovers
  task automatic t_wdog();
    sld_host_i.load();
    cmp("latch2", 8'hC3, led.led_on);
    wait_clk(WDOG + 40);
    cmp("wdog clr", 8'h00, led.led_on);
    cmp("wdog flag", 8'h01, {7'h00, fired});
    sld_host_i.xfer(8'hFF, rd);
    cmp("shift kept", 8'h3C, rd);
    cmp("stay off", 8'h00, led.led_on);
    cmp("flag clr", 8'h00, {7'h00, fired});
    sld_host_i.load();
    cmp("recover", 8'hFF, led.led_on);
  endtask : t_wdog
  // Report and stop
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  // Main sequence after a five cycle reset
  initial begin
    wait_clk(5);
    rst_n_i <= 1'b1;
    wait_clk(4);
    t_chain();
    t_gate();
    t_wdog();
    conclude();
  end
  // Hang guard, well past the expected 1300 cycles
  initial begin
    wait_clk(20000);
    n_errors++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
